// File: rtl/tlb_loopback.sv
`timescale 1ns/100ps
module tlb_loopback
  import tlb_pkg::*;
#(
  parameter int BUF_BITS = 4096,
  parameter int NUM_TF   = 4
) (
  input  wire logic                             clk_i,
  input  wire logic                             srst_i,
  input  wire logic                             bidir_bearer_i,
  input  wire logic                             test_mode_active_i,
  input  wire logic                             close_cmd_i,
  input  wire tlb_mode_e                        close_mode_i,
  input  wire tlb_setup_s [TLB_MAX_ENTRIES-1:0] close_setup_i,
  input  wire logic                             loop_release_command_i,
  output logic                                  close_ack_o,
  output logic                                  loop_release_ack_o,
  output logic                                  loop_closed_o,
  output tlb_mode_e                             loop_mode_o,
  input  wire logic                             ul_var_rate_i,
  input  wire logic [TLB_SIZE_W-1:0]            tf_size_i [NUM_TF],
  input  wire logic [$clog2(NUM_TF+1)-1:0]      tf_count_i,
  input  wire logic                             dl_valid_i,
  input  wire tlb_dl_beat_s                     dl_i,
  output logic                                  dl_ready_o,
  output logic                                  ul_valid_o,
  output tlb_ul_beat_s                          ul_o,
  input  wire logic                             ul_ready_i
);
  localparam int IDX_W = $clog2(BUF_BITS);
  localparam logic [TLB_SIZE_W-1:0] BUF_CAP = TLB_SIZE_W'(BUF_BITS);

  tlb_state_e                       state_reg;
  tlb_state_e                       state_next;
  logic                             closed_reg;
  tlb_mode_e                        mode_reg;
  tlb_setup_s [TLB_MAX_ENTRIES-1:0] setup_reg;
  logic                             close_ack_reg;
  logic                             rel_ack_reg;
  logic [BUF_BITS-1:0]              buf_reg;
  logic [TLB_SIZE_W-1:0]            dl_len_reg;
  logic [TLB_ID_W-1:0]              bearer_reg;
  logic                             hc_reg;
  logic [TLB_SIZE_W-1:0]            ul_len_reg;
  logic [TLB_SIZE_W-1:0]            out_cnt_reg;
  logic [TLB_SIZE_W-1:0]            rd_idx_reg;
  logic                             ul_data_reg;
  logic                             ul_last_reg;
  logic [TLB_SIZE_W-1:0]            ul_len_next;
  logic                             dl_take;
  logic                             ul_take;
  logic                             rd_in_block;
  logic                             load_reg;

  // per-bearer size lookup; identities outside the legal range never match
  function automatic logic [TLB_SIZE_W:0] tlb_lookup(
    input tlb_setup_s [TLB_MAX_ENTRIES-1:0] tab,
    input logic [TLB_ID_W-1:0]              id
  );
    logic [TLB_SIZE_W:0] res;
    res = '0;
    for (int i = TLB_MAX_ENTRIES - 1; i >= 0; i--) begin
      if (tab[i].valid && tab[i].bearer == id &&
          id >= TLB_ID_MIN && id <= TLB_ID_MAX) begin
        res = {1'b1, tab[i].uplink_sdu_length};
      end
    end
    return res;
  endfunction : tlb_lookup

  // smallest format that fits, else the largest configured one
  function automatic logic [TLB_SIZE_W-1:0] tlb_pick_tf(
    input logic [TLB_SIZE_W-1:0]       need,
    input logic [TLB_SIZE_W-1:0]       sizes [NUM_TF],
    input logic [$clog2(NUM_TF+1)-1:0] cnt
  );
    logic [TLB_SIZE_W-1:0] best;
    logic [TLB_SIZE_W-1:0] big;
    logic                  fit;
    best = '1;
    big  = '0;
    fit  = 1'b0;
    for (int i = 0; i < NUM_TF; i++) begin
      if (i < int'(cnt)) begin
        if (sizes[i] > big) begin
          big = sizes[i];
        end
        if (sizes[i] >= need && sizes[i] <= best) begin
          best = sizes[i];
          fit  = 1'b1;
        end
      end
    end
    return fit ? best : big;
  endfunction : tlb_pick_tf

  assign dl_take     = dl_valid_i && dl_ready_o;
  assign ul_take     = ul_valid_o && ul_ready_i;
  // stalls the downlink while a looped block is still going out
  assign dl_ready_o  = (state_reg != TLB_ST_SEND);
  // no beat during the load cycle, and none at all for a zero length
  assign ul_valid_o  = (state_reg == TLB_ST_SEND) && !load_reg &&
                       (ul_len_reg != TLB_SIZE_ZERO);
  assign ul_o.data   = ul_data_reg;
  assign ul_o.last   = ul_last_reg;
  assign ul_o.bearer = bearer_reg;
  assign close_ack_o        = close_ack_reg;
  assign loop_release_ack_o = rel_ack_reg;
  assign loop_closed_o      = closed_reg;
  assign loop_mode_o        = mode_reg;
  assign rd_in_block        = (rd_idx_reg < dl_len_reg);

  // loop control and command handshake
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      closed_reg    <= 1'b0;
      mode_reg      <= TLB_MODE_1;
      setup_reg     <= '0;
      close_ack_reg <= 1'b0;
      rel_ack_reg   <= 1'b0;
    end else begin
      close_ack_reg <= 1'b0;
      rel_ack_reg   <= 1'b0;
      if (loop_release_command_i && bidir_bearer_i) begin
        closed_reg  <= 1'b0;
        rel_ack_reg <= 1'b1;
      end else if (close_cmd_i && bidir_bearer_i && test_mode_active_i) begin
        // a second close while closed is acked without rereading the setup
        if (!closed_reg) begin
          closed_reg <= 1'b1;
          mode_reg   <= close_mode_i;
          setup_reg  <= close_setup_i;
        end
        close_ack_reg <= 1'b1;
      end
      if (!bidir_bearer_i) begin
        closed_reg <= 1'b0;
      end
    end
  end

  // uplink length for the block just received
  always_comb begin
    logic [TLB_SIZE_W:0] hit;
    hit         = tlb_lookup(setup_reg, bearer_reg);
    ul_len_next = dl_len_reg;
    if (mode_reg == TLB_MODE_2) begin
      // block and CRC arrive as one bit stream, so dl_len holds their sum
      ul_len_next = ul_var_rate_i ? tlb_pick_tf(dl_len_reg, tf_size_i, tf_count_i)
                                  : tf_size_i[0];
    end else if (!hc_reg) begin
      ul_len_next = hit[TLB_SIZE_W] ? hit[TLB_SIZE_W-1:0]
                                    : dl_len_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TLB_ST_IDLE: begin
        if (dl_take && closed_reg && !dl_i.last) begin
          state_next = TLB_ST_RECV;
        end else if (dl_take && closed_reg) begin
          state_next = TLB_ST_SEND;
        end
      end
      TLB_ST_RECV: begin
        if (dl_take && dl_i.last) begin
          state_next = TLB_ST_SEND;
        end
      end
      TLB_ST_SEND: begin
        if (!load_reg && (ul_len_reg == TLB_SIZE_ZERO ||
            (ul_take && ul_last_reg))) begin
          state_next = TLB_ST_IDLE;
        end
      end
      default: begin
        state_next = TLB_ST_IDLE;
      end
    endcase
  end

  // fixed latency: output starts two edges after the last downlink bit,
  // far inside one interval, so the frame delay never varies
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= TLB_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // downlink capture; bits past the buffer size are dropped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      buf_reg    <= '0;
      dl_len_reg <= '0;
      bearer_reg <= '0;
      hc_reg     <= 1'b0;
    end else if (dl_take && closed_reg && state_reg != TLB_ST_SEND) begin
      if (state_reg == TLB_ST_IDLE) begin
        buf_reg[0] <= dl_i.data;
        dl_len_reg <= TLB_SIZE_W'(1);
        bearer_reg <= dl_i.bearer;
        hc_reg     <= dl_i.header_compression_config;
      end else if (dl_len_reg < BUF_CAP) begin
        buf_reg[dl_len_reg[IDX_W-1:0]] <= dl_i.data;
        dl_len_reg <= dl_len_reg + TLB_SIZE_W'(1);
      end
    end
  end

  // first SEND cycle only loads: the length hangs on capture registers
  // written by the very edge that enters SEND
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= (state_reg != TLB_ST_SEND) && (state_next == TLB_ST_SEND);
    end
  end

  // uplink emission, one bit per accepted beat
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ul_len_reg  <= '0;
      out_cnt_reg <= '0;
      rd_idx_reg  <= '0;
      ul_data_reg <= 1'b0;
      ul_last_reg <= 1'b0;
    end else if (load_reg) begin
      ul_len_reg  <= ul_len_next;
      out_cnt_reg <= TLB_SIZE_W'(1);
      rd_idx_reg  <= TLB_SIZE_W'(1);
      ul_data_reg <= buf_reg[0];
      ul_last_reg <= (ul_len_next == TLB_SIZE_W'(1));
    end else if (ul_take) begin
      out_cnt_reg <= out_cnt_reg + TLB_SIZE_W'(1);
      ul_last_reg <= (out_cnt_reg + TLB_SIZE_W'(1) == ul_len_reg);
      if (mode_reg == TLB_MODE_2) begin
        // past the block plus CRC the spare uplink bits are zero
        ul_data_reg <= rd_in_block ? buf_reg[rd_idx_reg[IDX_W-1:0]] : 1'b0;
        rd_idx_reg  <= rd_idx_reg + TLB_SIZE_W'(1);
      end else begin
        ul_data_reg <= rd_in_block ? buf_reg[rd_idx_reg[IDX_W-1:0]]
                                   : buf_reg[0];
        rd_idx_reg  <= rd_in_block ? rd_idx_reg + TLB_SIZE_W'(1)
                                   : TLB_SIZE_W'(1);
      end
    end
  end
  // throughput is one bit per clock, thousands of SDUs per interval
endmodule : tlb_loopback

// File: rtl/tlb_pkg.sv
// Functional notes
// - mode 1 with header compression: loop each downlink SDU to uplink unchanged.
// - mode 1 without it: loop RLC SDU, uplink size from bearer setup entry.
// - bearer without setup entry: uplink size equals received downlink size.
// - uplink size zero: nothing is returned for that SDU.
// - uplink size equal to downlink size: whole block returned unchanged.
// - uplink size K smaller: return only first K bits.
// - uplink size larger: repeat received block, last repetition truncated.
// - mode 2: copy transport block plus CRC bits into uplink block.
// - variable rate: pick smallest uplink format holding block plus CRC.
// - nothing fits: truncate to largest configured uplink format.
// - loopback delay fixed while closed-loop configuration is unchanged.
// - loopback delay at most ten transmission intervals.
// - mode 1 delay limit applies for transparent, unsegmented bearers.
// - mode 2 delay limit applies for every bearer configuration.
// - mode 1: at least four SDUs per bearer per transmission interval.
// - no bidirectional bearer: ignore release command, send no reply.
// - loops closed and release arrives: open all, then acknowledge.
// - loops already open: still acknowledge the release command.
// - setup entry holds sixteen-bit uplink size, 0 to 65535 bits.
// - at most five setup entries, bearer identity 5 to 32.
package tlb_pkg;
  localparam int          TLB_SIZE_W      = 16;
  localparam int          TLB_ID_W        = 6;
  localparam int          TLB_MAX_ENTRIES = 5;
  localparam logic [5:0]  TLB_ID_MIN      = 6'h05;
  localparam logic [5:0]  TLB_ID_MAX      = 6'h20;
  localparam logic [15:0] TLB_SIZE_ZERO   = 16'h0000;

  typedef enum logic [1:0] {
    TLB_MODE_1 = 2'h0,
    TLB_MODE_2 = 2'h1
  } tlb_mode_e;

  typedef enum logic [1:0] {
    TLB_ST_IDLE = 2'h0,
    TLB_ST_RECV = 2'h1,
    TLB_ST_SEND = 2'h3
  } tlb_state_e;

  typedef struct packed {
    logic                  valid;
    logic [TLB_ID_W-1:0]   bearer;
    logic [TLB_SIZE_W-1:0] uplink_sdu_length;
  } tlb_setup_s;

  typedef struct packed {
    logic                data;
    logic                last;
    logic [TLB_ID_W-1:0] bearer;
    logic                header_compression_config;
  } tlb_dl_beat_s;

  typedef struct packed {
    logic                data;
    logic                last;
    logic [TLB_ID_W-1:0] bearer;
  } tlb_ul_beat_s;
endpackage : tlb_pkg

// File: testbench/tlb_loopback_props.sv
`timescale 1ns/100ps
module tlb_loopback_props
  import tlb_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         srst_i,
  input wire logic         bidir_bearer_i,
  input wire logic         test_mode_active_i,
  input wire logic         close_cmd_i,
  input wire logic         loop_release_command_i,
  input wire logic         close_ack_o,
  input wire logic         loop_release_ack_o,
  input wire logic         loop_closed_o,
  input wire tlb_mode_e    loop_mode_o,
  input wire logic         dl_valid_i,
  input wire tlb_dl_beat_s dl_i,
  input wire logic         dl_ready_o,
  input wire logic         ul_valid_o,
  input wire tlb_ul_beat_s ul_o,
  input wire logic         ul_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_release_acked: assert property (loop_release_command_i && bidir_bearer_i |=>
    loop_release_ack_o) else $error("release not acknowledged");
  chk_release_ignored: assert property (loop_release_command_i && !bidir_bearer_i |=>
    !loop_release_ack_o) else $error("release acknowledged without bearer");
  chk_release_opens: assert property (loop_release_command_i && bidir_bearer_i |=>
    !loop_closed_o) else $error("loop still closed after release");
  chk_close_taken: assert property (close_cmd_i && bidir_bearer_i && test_mode_active_i
    && !loop_release_command_i |=> close_ack_o && loop_closed_o) else $error("close not taken");
  chk_mode_held: assert property (loop_closed_o && $past(loop_closed_o) |->
    $stable(loop_mode_o)) else $error("loop mode changed while closed");
  chk_ul_beat_held: assert property (ul_valid_o && !ul_ready_i && $past(ul_valid_o) |=>
    ul_valid_o && $stable(ul_o)) else $error("uplink beat dropped before ready");
  chk_ul_latency: assert property (dl_valid_i && dl_ready_o && dl_i.last && loop_closed_o
    |=> !ul_valid_o && !dl_ready_o ##1 !dl_ready_o ##1 (ul_valid_o || dl_ready_o))
    else $error("uplink timing after last bit broken");
  chk_dl_stalled: assert property (ul_valid_o |-> !dl_ready_o)
    else $error("downlink accepted while sending");
endmodule : tlb_loopback_props

bind tlb_loopback tlb_loopback_props tlb_loopback_props_inst (.clk_i, .srst_i, .bidir_bearer_i,
  .test_mode_active_i, .close_cmd_i, .loop_release_command_i, .close_ack_o, .loop_release_ack_o,
  .loop_closed_o, .loop_mode_o, .dl_valid_i, .dl_i, .dl_ready_o, .ul_valid_o, .ul_o, .ul_ready_i);

// File: testbench/tlb_tester.sv
`timescale 1ns/100ps
module tlb_tester
  import tlb_pkg::*;
#(
  parameter int TIMER_CYC = 64
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         send_i,
  input  wire logic         loop_release_ack_i,
  input  wire logic         ul_valid_i,
  input  wire tlb_ul_beat_s ul_i,
  output logic              ul_ready_o,
  output logic              loop_release_command_o,
  output logic              got_ack_o,
  output logic              timed_out_o
);
  // timer scaled down from seconds so the run stays short
  int   timer_reg;
  logic run_reg;
  logic [1:0] stall_reg;
  logic rx_bits[$];
  int   n_last;
  always_ff @(posedge clk_i) begin
    loop_release_command_o <= send_i;
    if (srst_i || send_i) begin
      run_reg <= send_i;
      timer_reg <= 0;
      got_ack_o <= 1'b0;
      timed_out_o <= 1'b0;
    end else if (run_reg && loop_release_ack_i) begin
      run_reg <= 1'b0;
      got_ack_o <= 1'b1;
    end else if (run_reg) begin
      timer_reg <= timer_reg + 1;
      if (timer_reg == TIMER_CYC) begin
        run_reg <= 1'b0;
        timed_out_o <= 1'b1;
      end
    end
  end
  // every third cycle stalls, so uplink beats must wait
  always @(posedge clk_i) begin
    stall_reg <= (srst_i || stall_reg == 2'h2) ? 2'h0 : stall_reg + 2'h1;
    ul_ready_o <= (stall_reg != 2'h1);
    if (srst_i) begin
      n_last <= 0;
    end else if (ul_valid_i && ul_ready_o) begin
      rx_bits.push_back(ul_i.data);
      if (ul_i.last) n_last <= n_last + 1;
    end
  end
endmodule : tlb_tester

// File: testbench/tlb_loopback_test.sv
`timescale 1ns/100ps
module tlb_loopback_test;
  import tlb_pkg::*;
  logic clk_i = 0, srst_i = 1, bidir = 0, tmode = 0, close_cmd = 0, rel_send = 0;
  logic var_rate = 1, dl_valid = 0;
  tlb_mode_e mode = TLB_MODE_1;
  tlb_setup_s [TLB_MAX_ENTRIES-1:0] setup;
  logic [TLB_SIZE_W-1:0] tf_size [4] = '{16'h0004, 16'h0008, 16'h000C, 16'h0010};
  tlb_dl_beat_s dl = '0;
  wire rel_cmd, rel_ack, close_ack, closed, dl_ready, ul_valid, ul_ready, got_ack, t_out;
  tlb_mode_e loop_mode;
  tlb_ul_beat_s ul;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  tlb_loopback #(.BUF_BITS(64), .NUM_TF(4)) tlb_loopback_inst (.clk_i, .srst_i,
    .bidir_bearer_i(bidir), .test_mode_active_i(tmode), .close_cmd_i(close_cmd),
    .close_mode_i(mode), .close_setup_i(setup), .loop_release_command_i(rel_cmd),
    .close_ack_o(close_ack), .loop_release_ack_o(rel_ack), .loop_closed_o(closed),
    .loop_mode_o(loop_mode), .ul_var_rate_i(var_rate), .tf_size_i(tf_size),
    .tf_count_i(3'h4), .dl_valid_i(dl_valid), .dl_i(dl), .dl_ready_o(dl_ready),
    .ul_valid_o(ul_valid), .ul_o(ul), .ul_ready_i(ul_ready));
  tlb_tester #(.TIMER_CYC(64)) tlb_tester_inst (.clk_i, .srst_i, .send_i(rel_send),
    .loop_release_ack_i(rel_ack), .ul_valid_i(ul_valid), .ul_i(ul), .ul_ready_o(ul_ready),
    .loop_release_command_o(rel_cmd), .got_ack_o(got_ack), .timed_out_o(t_out));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic release_loop(logic exp_ack);
    @(posedge clk_i);
    rel_send <= 1;
    @(posedge clk_i);
    rel_send <= 0;
    repeat (70) @(posedge clk_i);
    #1 check("release ack", got_ack, exp_ack);
    check("timeout", t_out, !exp_ack);
    check("closed after release", closed, 1'b0);
  endtask : release_loop
  task automatic close_loop(tlb_mode_e m, logic exp_ack);
    @(posedge clk_i);
    mode <= m;
    close_cmd <= 1;
    @(posedge clk_i);
    close_cmd <= 0;
    #1 check("close ack", close_ack, exp_ack);
    check("closed", closed, exp_ack);
  endtask : close_loop
  // sends n bits of pat, then compares the uplink against k expected bits
  task automatic loop_block(logic [5:0] brr, logic hc, int n, int k, logic [31:0] pat);
    int i;
    int base;
    base = tlb_tester_inst.n_last;
    tlb_tester_inst.rx_bits.delete();
    i = 0;
    while (i < n) begin
      @(posedge clk_i);
      dl_valid <= 1;
      dl <= '{data: pat[i], last: (i == n - 1), bearer: brr, header_compression_config: hc};
      // ready read off the edge, where it stands for the coming one
      #1 if (dl_ready === 1'b1) i++;
    end
    @(posedge clk_i);
    dl_valid <= 0;
    for (i = 0; i < 300 && tlb_tester_inst.n_last == base; i++) @(posedge clk_i);
    #1 check("uplink blocks", tlb_tester_inst.n_last - base, (k == 0) ? 0 : 1);
    check("uplink length", tlb_tester_inst.rx_bits.size(), k);
    for (i = 0; i < k && i < tlb_tester_inst.rx_bits.size(); i++)
      check("uplink bit", tlb_tester_inst.rx_bits[i],
            (mode == TLB_MODE_1) ? pat[i % n] : (i < n && pat[i]));
  endtask : loop_block
  initial begin
    setup[0] = '{1'b1, 6'h05, 16'h0000};
    setup[1] = '{1'b1, 6'h06, 16'h0003};
    setup[2] = '{1'b1, 6'h07, 16'h000C};
    setup[3] = '{1'b1, 6'h08, 16'h0005};
    setup[4] = '{1'b0, 6'h09, 16'h0002};
    repeat (12) @(posedge clk_i);
    srst_i <= 0;
    release_loop(1'b0);
    @(posedge clk_i) bidir <= 1;
    close_loop(TLB_MODE_1, 1'b0);
    release_loop(1'b1);
    @(posedge clk_i) tmode <= 1;
    close_loop(TLB_MODE_1, 1'b1);
    loop_block(6'h05, 0, 5, 0, 32'h0000000B);
    loop_block(6'h06, 0, 5, 3, 32'h0000000B);
    loop_block(6'h07, 0, 5, 12, 32'h0000000B);
    loop_block(6'h08, 0, 5, 5, 32'h00000016);
    loop_block(6'h09, 0, 5, 5, 32'h00000019);
    loop_block(6'h06, 1, 5, 5, 32'h0000000D);
    close_loop(TLB_MODE_2, 1'b1);
    check("mode held", loop_mode, TLB_MODE_1);
    release_loop(1'b1);
    // the stream carries plain bits, as with ciphering switched off
    close_loop(TLB_MODE_2, 1'b1);
    loop_block(6'h0A, 0, 6, 8, 32'h0000002D);
    loop_block(6'h0A, 0, 20, 16, 32'h000A5C3B);
    @(posedge clk_i) var_rate <= 0;
    loop_block(6'h0A, 0, 6, 4, 32'h00000036);
    @(posedge clk_i) bidir <= 0;
    repeat (3) @(posedge clk_i);
    #1 check("closed without bearer", closed, 1'b0);
    final_report();
  end
endmodule : tlb_loopback_test
